// *** logic/bk2cc_top.v ***
// bk2cc_top.v: control and configuration logic of the second buck converter
// assumes one 20 MHz clock, synchronous inputs, an APB master with 32-bit data
//
// The APB interface to the registers was left to the implementer.

`include "bk2cc_consts.vh"

module bk2cc_top
#(
	parameter RAMP32_CYC = `BK2CC_RAMP32_CYC
)
(
	input  wire        I_SYS_CLK,
	input  wire        I_RST,
	input  wire        I_PSEL,
	input  wire        I_PENABLE,
	input  wire        I_PWRITE,
	input  wire [17:0] I_PADDR,
	input  wire [31:0] I_PWDATA,
	output reg         O_PREADY,
	output reg  [31:0] O_PRDATA,
	output reg         O_PSLVERR,
	input  wire        I_UV_FAULT,
	input  wire        I_HW_CTRL1,
	input  wire        I_HW_CTRL2,
	input  wire        I_HW_EN1,
	input  wire        I_HW_EN2,
	input  wire [2:0]  I_TIMESLOT,
	input  wire        I_SEQ_ACTIVE,
	input  wire        I_NV_LOAD,
	input  wire [4:0]  I_NV_VCODE,
	input  wire        I_OVERCURRENT,
	output reg         O_CONV_EN,
	output reg  [1:0]  O_CONV_MODE,
	output reg  [6:0]  O_VOUT_CODE,
	output reg  [2:0]  O_OC_LEVEL,
	output reg         O_OC_DETECT_EN,
	output reg         O_DEVICE_RESET,
	output reg         O_IRQ
);

	// register bits
	reg  [15:0] fault_hwc_r;
	reg  [15:0] on_cfg_r;
	reg  [6:0]  sleep_code_r;
	reg  [1:0]  ramp_r;
	reg  [1:0]  irq_stat_r;
	reg  [1:0]  irq_mask_r;
	reg         uv_off_r;
	reg         uv_prev_r;
	reg         oc_prev_r;
	reg  [15:0] ramp_cnt_r;
	reg  [6:0]  cur_code_r;
	reg         seq_on_r;

	// interval counts kept as integers, trimmed on purpose where used
	localparam integer RAMP16_LEN = `BK2CC_RAMP16_CYC;
	localparam integer RAMP8_LEN  = `BK2CC_RAMP8_CYC;

	wire [1:0] buck2_uv_fault_action      = fault_hwc_r[15:14];
	wire [1:0] buck2_hw_ctrl_source       = fault_hwc_r[12:11];
	wire       buck2_hw_ctrl_voltage_pick = fault_hwc_r[10];
	wire [1:0] buck2_hw_ctrl_op_mode      = fault_hwc_r[9:8];
	wire [2:0] buck2_overcurrent_level    = fault_hwc_r[6:4];
	wire       buck2_overcurrent_detect_en = fault_hwc_r[0];
	wire [2:0] buck2_startup_slot         = on_cfg_r[15:13];
	wire [1:0] buck2_normal_op_mode       = on_cfg_r[9:8];
	wire [6:0] buck2_normal_voltage_code  = on_cfg_r[6:0];

	// apb decode; access phase always ends after one wait cycle, ready the cycle after it starts
	wire        acc     = I_PSEL & I_PENABLE & ~O_PREADY;
	wire        wr      = acc & I_PWRITE;
	wire        a_fh    = (I_PADDR == `BK2CC_ADDR_FAULT_HWC);
	wire        a_on    = (I_PADDR == `BK2CC_ADDR_ON_CFG);
	wire        a_slp   = (I_PADDR == `BK2CC_ADDR_SLEEP_V);
	wire        a_rmp   = (I_PADDR == `BK2CC_ADDR_RAMP);
	wire        a_ist   = (I_PADDR == `BK2CC_ADDR_IRQ_STAT);
	wire        a_imk   = (I_PADDR == `BK2CC_ADDR_IRQ_MASK);
	wire        a_sts   = (I_PADDR == `BK2CC_ADDR_STATUS);
	wire        mapped  = a_fh | a_on | a_slp | a_rmp | a_ist | a_imk | a_sts;

	// hardware control selection
	reg hw_active;
	always @*
	begin
		case (buck2_hw_ctrl_source)
			2'h1:    hw_active = I_HW_CTRL1;
			2'h2:    hw_active = I_HW_CTRL2;
			2'h3:    hw_active = I_HW_CTRL1 | I_HW_CTRL2;
			default: hw_active = 1'b0;
		endcase
	end

	// start slot decode; timeslot enables are latched by the sequencer
	reg slot_en;
	always @*
	begin
		case (buck2_startup_slot)
			3'h0:    slot_en = 1'b0;
			3'h6:    slot_en = I_HW_EN1;
			3'h7:    slot_en = I_HW_EN2;
			default: slot_en = seq_on_r;
		endcase
	end

	// effective target and mode; hw control overrides while asserted
	wire [6:0] tgt_raw = (hw_active && buck2_hw_ctrl_voltage_pick) ?
		sleep_code_r : buck2_normal_voltage_code;
	wire [1:0] mode_eff = hw_active ? buck2_hw_ctrl_op_mode
		: buck2_normal_op_mode;
	// clamp below 08h and above 68h
	wire [6:0] tgt = (tgt_raw < `BK2CC_VCODE_MIN) ? `BK2CC_VCODE_MIN :
		(tgt_raw > `BK2CC_VCODE_MAX) ? `BK2CC_VCODE_MAX : tgt_raw;
	wire hw_off = hw_active && (buck2_hw_ctrl_op_mode == 2'h1);
	wire en_nxt = slot_en & ~hw_off & ~uv_off_r;

	// ramp interval in cycles per step
	reg [15:0] ramp_len;
	always @*
	begin
		case (ramp_r)
			2'h0:    ramp_len = RAMP32_CYC[15:0];
			2'h1:    ramp_len = RAMP16_LEN[15:0];
			2'h2:    ramp_len = RAMP8_LEN[15:0];
			default: ramp_len = 16'h0001;
		endcase
	end

	wire uv_rise = I_UV_FAULT & ~uv_prev_r;
	wire oc_rise = I_OVERCURRENT & ~oc_prev_r & buck2_overcurrent_detect_en;
	wire [1:0] ev = {oc_rise, uv_rise};

	// apb slave and register writes
	always @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			O_PREADY     <= 1'b0;
			O_PRDATA     <= 32'h0000_0000;
			O_PSLVERR    <= 1'b0;
			fault_hwc_r  <= `BK2CC_RST_FAULT_HWC;
			on_cfg_r     <= `BK2CC_RST_ON_CFG;
			sleep_code_r <= 7'h00;
			ramp_r       <= `BK2CC_RST_RAMP;
			irq_mask_r   <= 2'h0;
		end
		else
		begin
			O_PREADY  <= acc;
			O_PSLVERR <= acc & ~mapped;
			if (I_NV_LOAD)
				on_cfg_r[6:2] <= I_NV_VCODE;
			if (wr && a_fh)
				fault_hwc_r <= I_PWDATA[15:0] & 16'hdf71;
			if (wr && a_on && !I_NV_LOAD)
				on_cfg_r <= I_PWDATA[15:0] & 16'he37f;
			if (wr && a_slp)
				sleep_code_r <= I_PWDATA[6:0];
			if (wr && a_rmp)
				ramp_r <= I_PWDATA[1:0];
			if (wr && a_imk)
				irq_mask_r <= I_PWDATA[1:0];
			if (acc && !I_PWRITE)
			begin
				if (a_fh)
					O_PRDATA <= {16'h0000, fault_hwc_r};
				else if (a_on)
					O_PRDATA <= {16'h0000, on_cfg_r};
				else if (a_slp)
					O_PRDATA <= {25'h0, sleep_code_r};
				else if (a_rmp)
					O_PRDATA <= {30'h0, ramp_r};
				else if (a_ist)
					O_PRDATA <= {30'h0, irq_stat_r};
				else if (a_imk)
					O_PRDATA <= {30'h0, irq_mask_r};
				else if (a_sts)
					O_PRDATA <= {16'h0, O_CONV_EN, uv_off_r, hw_active,
						cur_code_r, O_CONV_MODE, 4'h0};
				else
					O_PRDATA <= 32'h0000_0000;
			end
		end
	end

	// sticky status; a new event wins over a write-one clear
	always @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			irq_stat_r <= 2'h0;
			O_IRQ      <= 1'b0;
			uv_prev_r  <= 1'b0;
			oc_prev_r  <= 1'b0;
		end
		else
		begin
			uv_prev_r  <= I_UV_FAULT;
			oc_prev_r  <= I_OVERCURRENT;
			irq_stat_r <= (irq_stat_r & ~((wr && a_ist) ? I_PWDATA[1:0]
				: 2'h0)) | ev;
			O_IRQ <= |(((irq_stat_r & ~((wr && a_ist) ? I_PWDATA[1:0]
				: 2'h0)) | ev) & irq_mask_r);
		end
	end

	// fault action, start sequence latch, outputs
	always @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			uv_off_r       <= 1'b0;
			seq_on_r       <= 1'b0;
			O_DEVICE_RESET <= 1'b0;
			O_CONV_EN      <= 1'b0;
			O_CONV_MODE    <= 2'h1;
			O_OC_LEVEL     <= 3'h0;
			O_OC_DETECT_EN <= 1'b0;
		end
		else
		begin
			if (uv_rise && buck2_uv_fault_action == 2'h1)
				uv_off_r <= 1'b1;
			else if (!slot_en)
				uv_off_r <= 1'b0; // re-arm once enable drops
			// reserved action 11 behaves as ignore
			O_DEVICE_RESET <= uv_rise && (buck2_uv_fault_action == 2'h2);
			if (buck2_startup_slot == 3'h0 || buck2_startup_slot > 3'h5)
				seq_on_r <= 1'b0;
			else if (I_SEQ_ACTIVE && I_TIMESLOT == buck2_startup_slot)
				seq_on_r <= 1'b1;
			O_CONV_EN      <= en_nxt;
			O_CONV_MODE    <= mode_eff;
			O_OC_LEVEL     <= buck2_overcurrent_level;
			O_OC_DETECT_EN <= buck2_overcurrent_detect_en;
		end
	end

	// voltage ramp, one 12.5 mV code per interval toward target; ramp setting 3 loads the target at once
	always @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			ramp_cnt_r  <= 16'h0000;
			cur_code_r  <= `BK2CC_VCODE_MIN;
			O_VOUT_CODE <= `BK2CC_VCODE_MIN;
		end
		else
		begin
			O_VOUT_CODE <= cur_code_r;
			if (ramp_r == 2'h3)
			begin
				cur_code_r <= tgt;
				ramp_cnt_r <= 16'h0000;
			end
			else if (cur_code_r == tgt)
				ramp_cnt_r <= 16'h0000;
			else if (ramp_cnt_r >= ramp_len - 16'h0001)
			begin
				ramp_cnt_r <= 16'h0000;
				cur_code_r <= (cur_code_r < tgt) ? cur_code_r + 7'h01
					: cur_code_r - 7'h01;
			end
			else
				ramp_cnt_r <= ramp_cnt_r + 16'h0001;
		end
	end

endmodule // bk2cc_top

// *** pkg/bk2cc_consts.vh ***
// bk2cc_consts.vh: offsets, indices, reset values, code limits and timing counts
// for the second buck converter control block; included by logic/bk2cc_top.v
`ifndef BK2CC_CONSTS_VH
`define BK2CC_CONSTS_VH

// register byte offsets (index times four; printed indices are not aligned)
`define BK2CC_IDX_FAULT_HWC   16'h405c
`define BK2CC_IDX_ON_CFG      16'h405d
`define BK2CC_ADDR_FAULT_HWC  18'h1_0170
`define BK2CC_ADDR_ON_CFG     18'h1_0174
`define BK2CC_ADDR_SLEEP_V    18'h0_0000
`define BK2CC_ADDR_RAMP       18'h0_0004
`define BK2CC_ADDR_IRQ_STAT   18'h0_0008
`define BK2CC_ADDR_IRQ_MASK   18'h0_000c
`define BK2CC_ADDR_STATUS     18'h0_0010

// field reset values
`define BK2CC_RST_FAULT_HWC   16'h0300
`define BK2CC_RST_ON_CFG      16'h0100
`define BK2CC_RST_RAMP        2'h2

// voltage code limits
`define BK2CC_VCODE_MIN       7'h08
`define BK2CC_VCODE_MAX       7'h68

// ramp intervals in ns and at a 50 ns clock
`define BK2CC_CLK_NS          50
`define BK2CC_RAMP32_NS       32000
`define BK2CC_RAMP16_NS       16000
`define BK2CC_RAMP8_NS        8000
`define BK2CC_RAMP32_CYC      (`BK2CC_RAMP32_NS / `BK2CC_CLK_NS)
`define BK2CC_RAMP16_CYC      (`BK2CC_RAMP16_NS / `BK2CC_CLK_NS)
`define BK2CC_RAMP8_CYC       (`BK2CC_RAMP8_NS / `BK2CC_CLK_NS)

`endif

// *** verification/bk2cc_asserts.sv ***
// bk2cc_asserts.sv: port-level checks for the buck2 control block
// assumes bind onto bk2cc_top, one clock, sync active-high reset
module bk2cc_asserts
#(
	parameter RAMP32_CYC = 640
)
(
	input wire logic       I_SYS_CLK,
	input wire logic       I_RST,
	input wire logic       I_PSEL,
	input wire logic       I_PENABLE,
	input wire logic       I_PWRITE,
	input wire logic       O_PREADY,
	input wire logic       O_PSLVERR,
	input wire logic       I_UV_FAULT,
	input wire logic       O_DEVICE_RESET,
	input wire logic [6:0] O_VOUT_CODE,
	input wire logic [2:0] O_OC_LEVEL,
	input wire logic       O_OC_DETECT_EN
);
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);
	// access phase waiting for its answer
	sequence acc_s;
		I_PSEL && I_PENABLE && !O_PREADY;
	endsequence
	// field outputs only move after a register write
	sequence wr_s;
		$past(I_PSEL && I_PWRITE) || $past(I_PSEL && I_PWRITE, 2);
	endsequence
	ready_answer_a: assert property (acc_s |=> O_PREADY)
		else $error("no ready after access phase");
	ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");
	err_with_ready_a: assert property (O_PSLVERR |-> O_PREADY)
		else $error("slave error without ready");
	rst_pulse_a: assert property (O_DEVICE_RESET |=> !O_DEVICE_RESET)
		else $error("device reset not a pulse");
	rst_cause_a: assert property (O_DEVICE_RESET |-> I_UV_FAULT || $past(I_UV_FAULT))
		else $error("device reset without fault");
	vout_range_a: assert property (O_VOUT_CODE >= 7'h08 && O_VOUT_CODE <= 7'h68)
		else $error("voltage code outside clamp");
	oc_level_hold_a: assert property (!$stable(O_OC_LEVEL) |-> wr_s)
		else $error("threshold moved without write");
	oc_en_hold_a: assert property (!$stable(O_OC_DETECT_EN) |-> wr_s)
		else $error("detect enable moved without write");
endmodule // bk2cc_asserts

bind bk2cc_top bk2cc_asserts #(.RAMP32_CYC(RAMP32_CYC)) bk2cc_asserts_i
	(.I_SYS_CLK, .I_RST, .I_PSEL, .I_PENABLE, .I_PWRITE, .O_PREADY,
	.O_PSLVERR, .I_UV_FAULT, .O_DEVICE_RESET, .O_VOUT_CODE, .O_OC_LEVEL,
	.O_OC_DETECT_EN);

// *** verification/bk2cc_top_bench.sv ***
// bk2cc_top_bench.sv: self-checking bench for the buck2 control block
// assumes bk2cc_top with its checker bound; this bench is the APB master
`include "bk2cc_consts.vh"
module bk2cc_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        I_SYS_CLK = 0, I_RST = 1, I_PSEL = 0, I_PENABLE = 0;
	logic        I_PWRITE = 0, I_UV_FAULT = 0, I_HW_CTRL1 = 0, I_HW_CTRL2 = 0;
	logic        I_HW_EN1 = 0, I_HW_EN2 = 0, I_SEQ_ACTIVE = 0, I_NV_LOAD = 0;
	logic        I_OVERCURRENT = 0;
	logic [17:0] I_PADDR = 0;
	logic [31:0] I_PWDATA = 0;
	logic [2:0]  I_TIMESLOT = 0;
	logic [4:0]  I_NV_VCODE = 0;
	wire         O_PREADY, O_PSLVERR, O_CONV_EN, O_OC_DETECT_EN;
	wire         O_DEVICE_RESET, O_IRQ;
	wire  [31:0] O_PRDATA;
	wire  [1:0]  O_CONV_MODE;
	wire  [6:0]  O_VOUT_CODE;
	wire  [2:0]  O_OC_LEVEL;
	logic [32:0] notes[$];
	logic [6:0]  vc[4] = '{7'h7f, 7'h00, 7'h48, 7'h09};
	logic [6:0]  vx[4] = '{7'h68, 7'h08, 7'h48, 7'h09};
	logic [31:0] d;
	logic        seen;
	int          n_fail = 0, checked = 0;

	always #25 I_SYS_CLK = ~I_SYS_CLK;

	// small ramp count keeps ramp tests short
	bk2cc_top #(.RAMP32_CYC(8)) bk2cc_top_i (.I_SYS_CLK, .I_RST, .I_PSEL,
		.I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PREADY, .O_PRDATA,
		.O_PSLVERR, .I_UV_FAULT, .I_HW_CTRL1, .I_HW_CTRL2, .I_HW_EN1,
		.I_HW_EN2, .I_TIMESLOT, .I_SEQ_ACTIVE, .I_NV_LOAD, .I_NV_VCODE,
		.I_OVERCURRENT, .O_CONV_EN, .O_CONV_MODE, .O_VOUT_CODE, .O_OC_LEVEL,
		.O_OC_DETECT_EN, .O_DEVICE_RESET, .O_IRQ);

	task close_out;
		if (n_fail == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input [63:0] s, input [63:0] e);
		checked++;
		if (s !== e)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// holds the whole request until ready is seen at an edge
	task apb(input [17:0] a, input w, input [31:0] v);
		int n;
		n = 0;
		I_PSEL <= 1'b1;
		I_PWRITE <= w;
		I_PADDR <= a;
		I_PWDATA <= v;
		@(posedge I_SYS_CLK);
		I_PENABLE <= 1'b1;
		do
		begin
			@(posedge I_SYS_CLK);
			n++;
		end
		while (O_PREADY !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			n_fail++;
			close_out;
		end
		I_PSEL <= 1'b0;
		I_PENABLE <= 1'b0;
		@(posedge I_SYS_CLK);
	endtask

	task rd(input [17:0] a, input [32:0] e);
		notes.push_back(e);
		apb(a, 1'b0, 32'h0);
	endtask

	task st;
		repeat (4) @(posedge I_SYS_CLK);
	endtask

	// fault pulse, also catching any device reset pulse
	task uv;
		I_UV_FAULT <= 1'b1;
		seen = 0;
		repeat (4)
		begin
			@(posedge I_SYS_CLK);
			seen |= O_DEVICE_RESET;
		end
		I_UV_FAULT <= 1'b0;
		st;
	endtask

	// read answers are matched against the oldest note
	always @(posedge I_SYS_CLK)
		if (I_PSEL && I_PENABLE && O_PREADY === 1'b1 && !I_PWRITE)
			chk({O_PSLVERR, O_PRDATA}, notes.size() ? notes.pop_front() : '1);

	// a hang ends the run as a failure
	initial
	begin
		repeat (20000) @(posedge I_SYS_CLK);
		n_fail++;
		close_out;
	end

	initial
	begin
		void'($urandom(32'h6ee5));
		repeat (3) @(posedge I_SYS_CLK);
		I_RST <= 1'b0;
		@(posedge I_SYS_CLK);
		rd(`BK2CC_ADDR_FAULT_HWC, 33'h300);
		rd(`BK2CC_ADDR_ON_CFG, 33'h100);
		rd(18'h20, 33'h1_0000_0000);
		for (int i = 0; i < 4; i++)
		begin
			d = $urandom;
			apb(`BK2CC_ADDR_FAULT_HWC, 1'b1, d);
			rd(`BK2CC_ADDR_FAULT_HWC, d & 32'hdf71);
			st;
			chk({O_OC_LEVEL, O_OC_DETECT_EN}, {d[6:4], d[0]});
		end
		apb(`BK2CC_ADDR_ON_CFG, 1'b1, 32'h0);
		I_NV_VCODE <= 5'h15;
		I_NV_LOAD <= 1'b1;
		@(posedge I_SYS_CLK);
		I_NV_LOAD <= 1'b0;
		rd(`BK2CC_ADDR_ON_CFG, 33'h54);
		apb(`BK2CC_ADDR_RAMP, 1'b1, 32'h3);
		apb(`BK2CC_ADDR_FAULT_HWC, 1'b1, 32'h0);
		I_HW_EN1 <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			apb(`BK2CC_ADDR_ON_CFG, 1'b1, 32'hc000 | i << 8 | vc[i]);
			st;
			chk({O_CONV_EN, O_CONV_MODE, O_VOUT_CODE}, {1'b1, i[1:0], vx[i]});
		end
		apb(`BK2CC_ADDR_SLEEP_V, 1'b1, 32'h20);
		for (int s = 1; s < 4; s++)
		begin
			apb(`BK2CC_ADDR_FAULT_HWC, 1'b1, s << 11 | 32'h600);
			I_HW_CTRL1 <= 1'b1;
			st;
			chk({O_CONV_MODE, O_VOUT_CODE}, s == 2 ? 9'h189 : 9'h120);
			I_HW_CTRL1 <= 1'b0;
			st;
			chk({O_CONV_MODE, O_VOUT_CODE}, 9'h189);
		end
		// slow ramp, 8 cycles a step: 09h to 0ch needs about 24
		apb(`BK2CC_ADDR_RAMP, 1'b1, 32'h0);
		apb(`BK2CC_ADDR_ON_CFG, 1'b1, 32'hc30c);
		st;
		chk(O_VOUT_CODE, 7'h09);
		repeat (40) @(posedge I_SYS_CLK);
		chk(O_VOUT_CODE, 7'h0c);
		rd(`BK2CC_ADDR_STATUS, 33'h8330);
		apb(`BK2CC_ADDR_IRQ_MASK, 1'b1, 32'h1);
		apb(`BK2CC_ADDR_FAULT_HWC, 1'b1, 32'h0);
		uv;
		chk({O_IRQ, O_CONV_EN, seen}, 3'b110);
		rd(`BK2CC_ADDR_IRQ_STAT, 33'h1);
		apb(`BK2CC_ADDR_IRQ_STAT, 1'b1, 32'h1);
		apb(`BK2CC_ADDR_IRQ_MASK, 1'b1, 32'h0);
		apb(`BK2CC_ADDR_FAULT_HWC, 1'b1, 32'h4000);
		uv;
		chk({O_IRQ, O_CONV_EN, seen}, 3'b000);
		apb(`BK2CC_ADDR_FAULT_HWC, 1'b1, 32'h8000);
		uv;
		chk(seen, 1'b1);
		close_out;
	end
endmodule // bk2cc_top_bench
